//--- design/port_stat_counter_indirect_read.v
// per-port statistics counter indirect read register bank
// What this block does
// - each port keeps thirty counters that software reaches only through one control/status and one data register.
// - reading a counter through the indirect mechanism restarts it from zero, counting an event of the same cycle.
// - the block clears bit 25 itself once the counter value sits in the value fields.
// - bits 35:32 of the counter value read back in control/status bits 3:0.
// - bits 31:0 of the counter value read back in the data register.
// - control/status bit 31 shows one when the read counter had overflowed, zero otherwise.
// - with bit 24 set the port obeys the global flush and freeze commands, with it clear it ignores them.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`include "stat_counter_defs.vh"

module port_stat_counter_indirect_read (
    input wire i_clk,
    input wire i_sys_rst,
    input wire [`SC_ADDR_W-1:0] i_addr,
    input wire [`SC_DATA_W-1:0] i_wr_data,
    input wire i_wr_en,
    input wire i_rd_en,
    output reg [`SC_DATA_W-1:0] o_rd_data,
    input wire [`SC_NUM_COUNTERS-1:0] i_cnt_event,
    input wire i_global_flush,
    input wire i_global_freeze,
    output reg o_read_busy,
    output reg o_port_frozen
);
    // software visible fields
    reg rd_busy_r;
    reg rd_busy_nxt;
    reg ffe_r;
    reg ffe_nxt;
    reg [`SC_IDX_W-1:0] idx_r;
    reg [`SC_IDX_W-1:0] idx_nxt;
    reg ovf_r;
    reg ovf_nxt;
    reg [`SC_CNT_HI_W-1:0] val_hi_r;
    reg [`SC_CNT_HI_W-1:0] val_hi_nxt;
    reg [`SC_DATA_W-1:0] val_lo_r;
    reg [`SC_DATA_W-1:0] val_lo_nxt;

    // read sequencer
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ISSUE = 2'h1;
    localparam [1:0] ST_WAIT = 2'h2;
    reg [1:0] state_r;
    reg [1:0] state_nxt;

    // read data path
    reg [`SC_DATA_W-1:0] rd_data_nxt;

    // decoded strobes
    wire csr_hit;
    wire data_hit;
    wire csr_wr;
    wire start_rd;

    // counter bank handshake
    wire bank_rd_req;
    wire [`SC_CNT_W-1:0] bank_value;
    wire bank_ovf;
    wire bank_done;

    // qualified global controls
    wire port_freeze;
    wire port_flush;

    // address match against one register offset
    function addr_is;
        input [`SC_ADDR_W-1:0] addr;
        input [`SC_ADDR_W-1:0] offset;
        begin
            addr_is = (addr == offset);
        end
    endfunction

    // assemble the control/status word from its fields
    function [`SC_DATA_W-1:0] csr_word;
        input ovf;
        input busy;
        input ffe;
        input [`SC_IDX_W-1:0] idx;
        input [`SC_CNT_HI_W-1:0] hi;
        reg [`SC_DATA_W-1:0] w;
        begin
            w = {`SC_DATA_W{1'b0}};
            w[`SC_CSR_OVF_BIT] = ovf;
            w[`SC_CSR_RD_BIT] = busy;
            w[`SC_CSR_FFE_BIT] = ffe;
            w[`SC_CSR_IDX_MSB:`SC_CSR_IDX_LSB] = idx;
            w[`SC_CSR_HI_MSB:`SC_CSR_HI_LSB] = hi;
            csr_word = w;
        end
    endfunction

    // address decoding
    assign csr_hit = addr_is(i_addr, `SC_CSR_OFFSET);
    assign data_hit = addr_is(i_addr, `SC_DATA_OFFSET);
    assign csr_wr = i_wr_en && csr_hit;
    assign start_rd = csr_wr && i_wr_data[`SC_CSR_RD_BIT] && !rd_busy_r;

    // global flush and freeze reach this port only when enabled
    assign port_freeze = i_global_freeze && ffe_r;
    assign port_flush = i_global_flush && ffe_r;

    // one-cycle request to the bank while issuing
    assign bank_rd_req = (state_r == ST_ISSUE);

    stat_counter_bank u_bank (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_cnt_event(i_cnt_event),
        .i_freeze(port_freeze),
        .i_flush(port_flush),
        .i_rd_req(bank_rd_req),
        .i_rd_idx(idx_r),
        .o_rd_value(bank_value),
        .o_rd_ovf(bank_ovf),
        .o_rd_done(bank_done)
    );

    // read sequencer: issue to the bank, then wait for its captured value
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_rd) begin
                    state_nxt = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                if (bank_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // control/status fields
    always @* begin
        rd_busy_nxt = rd_busy_r;
        ffe_nxt = ffe_r;
        idx_nxt = idx_r;
        if (csr_wr) begin
            ffe_nxt = i_wr_data[`SC_CSR_FFE_BIT];
            // index stays put while a read is in flight
            if (!rd_busy_r) begin
                idx_nxt = i_wr_data[`SC_CSR_IDX_MSB:`SC_CSR_IDX_LSB];
            end
        end
        if (start_rd) begin
            rd_busy_nxt = 1'b1;
        end else if (state_r == ST_WAIT && bank_done) begin
            rd_busy_nxt = 1'b0;
        end
    end

    // value fields load together with the clearing of the busy bit
    always @* begin
        ovf_nxt = ovf_r;
        val_hi_nxt = val_hi_r;
        val_lo_nxt = val_lo_r;
        if (state_r == ST_WAIT && bank_done) begin
            ovf_nxt = bank_ovf;
            val_hi_nxt = bank_value[`SC_CNT_W-1:`SC_DATA_W];
            val_lo_nxt = bank_value[`SC_DATA_W-1:0];
        end
    end

    // read data: valid only in the cycle after the strobe, zero elsewhere and for unmapped addresses
    always @* begin
        rd_data_nxt = {`SC_DATA_W{1'b0}};
        if (i_rd_en) begin
            if (csr_hit) begin
                rd_data_nxt = csr_word(ovf_r, rd_busy_r, ffe_r, idx_r, val_hi_r);
            end else if (data_hit) begin
                rd_data_nxt = val_lo_r;
            end else begin
                rd_data_nxt = {`SC_DATA_W{1'b0}};
            end
        end
    end

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= ST_IDLE;
            rd_busy_r <= 1'b0;
            ffe_r <= 1'b0;
            idx_r <= `SC_IDX_RESET;
            ovf_r <= 1'b0;
            val_hi_r <= {`SC_CNT_HI_W{1'b0}};
            val_lo_r <= `SC_DATA_RESET;
            o_rd_data <= {`SC_DATA_W{1'b0}};
            o_read_busy <= 1'b0;
            o_port_frozen <= 1'b0;
        end else begin
            state_r <= state_nxt;
            rd_busy_r <= rd_busy_nxt;
            ffe_r <= ffe_nxt;
            idx_r <= idx_nxt;
            ovf_r <= ovf_nxt;
            val_hi_r <= val_hi_nxt;
            val_lo_r <= val_lo_nxt;
            o_rd_data <= rd_data_nxt;
            o_read_busy <= rd_busy_nxt;
            o_port_frozen <= port_freeze;
        end
    end
endmodule

//--- design/stat_counter_bank.v
// thirty 36-bit statistics counters with read-and-clear, flush and freeze
`timescale 1ns/100ps
`include "stat_counter_defs.vh"

module stat_counter_bank (
    input wire i_clk,
    input wire i_sys_rst,
    input wire [`SC_NUM_COUNTERS-1:0] i_cnt_event,
    input wire i_freeze,
    input wire i_flush,
    input wire i_rd_req,
    input wire [`SC_IDX_W-1:0] i_rd_idx,
    output reg [`SC_CNT_W-1:0] o_rd_value,
    output reg o_rd_ovf,
    output reg o_rd_done
);
    reg [`SC_CNT_W-1:0] cnt_r [0:`SC_NUM_COUNTERS-1];
    reg [`SC_NUM_COUNTERS-1:0] ovf_r;
    wire idx_ok;
    integer k;

    assign idx_ok = (i_rd_idx < `SC_NUM_COUNTERS);

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (k = 0; k < `SC_NUM_COUNTERS; k = k + 1) begin
                cnt_r[k] <= {`SC_CNT_W{1'b0}};
            end
            ovf_r <= {`SC_NUM_COUNTERS{1'b0}};
            o_rd_value <= {`SC_CNT_W{1'b0}};
            o_rd_ovf <= 1'b0;
            o_rd_done <= 1'b0;
        end else begin
            o_rd_done <= i_rd_req;
            if (i_rd_req) begin
                o_rd_value <= idx_ok ? cnt_r[i_rd_idx[`SC_SEL_W-1:0]] : {`SC_CNT_W{1'b0}};
                o_rd_ovf <= idx_ok ? ovf_r[i_rd_idx[`SC_SEL_W-1:0]] : 1'b0;
            end
            for (k = 0; k < `SC_NUM_COUNTERS; k = k + 1) begin
                if (i_flush) begin
                    cnt_r[k] <= {`SC_CNT_W{1'b0}};
                    ovf_r[k] <= 1'b0;
                end else if (i_rd_req && idx_ok && (i_rd_idx[`SC_SEL_W-1:0] == k[`SC_SEL_W-1:0])) begin
                    // capture and clear in one edge; an event in the same cycle starts the new count
                    cnt_r[k] <= {{(`SC_CNT_W-1){1'b0}}, (i_cnt_event[k] & ~i_freeze)};
                    ovf_r[k] <= 1'b0;
                end else if (i_cnt_event[k] && !i_freeze) begin
                    cnt_r[k] <= cnt_r[k] + {{(`SC_CNT_W-1){1'b0}}, 1'b1};
                    if (&cnt_r[k]) begin
                        ovf_r[k] <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

//--- design/stat_counter_defs.vh
// constants for the per-port statistics counter access block
`ifndef STAT_COUNTER_DEFS_VH
`define STAT_COUNTER_DEFS_VH

// register bus geometry
`define SC_ADDR_W 12
`define SC_DATA_W 32

// register byte offsets
`define SC_CSR_OFFSET 12'h0500
`define SC_DATA_OFFSET 12'h0504

// counter geometry
`define SC_NUM_COUNTERS 30
`define SC_CNT_W 36
`define SC_IDX_W 8
`define SC_SEL_W 5
`define SC_CNT_HI_W 4

// control/status field positions
`define SC_CSR_OVF_BIT 31
`define SC_CSR_RD_BIT 25
`define SC_CSR_FFE_BIT 24
`define SC_CSR_IDX_MSB 23
`define SC_CSR_IDX_LSB 16
`define SC_CSR_HI_MSB 3
`define SC_CSR_HI_LSB 0

// reset values
`define SC_CSR_RESET 32'h0000_0000
`define SC_DATA_RESET 32'h0000_0000
`define SC_IDX_RESET 8'h00

`endif

//--- sim/host_model.sv
// host software model driving the register port
`timescale 1ns/100ps
module host_model (
    input wire i_clk,
    input wire [31:0] i_rd_data,
    output logic [11:0] o_addr = 12'h000,
    output logic [31:0] o_wr_data = 32'h0000_0000,
    output logic o_wr_en = 1'b0,
    output logic o_rd_en = 1'b0
);
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wr_data <= d;
        o_wr_en <= 1'b1;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
    endtask
    task rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd_en <= 1'b1;
        @(posedge i_clk);
        o_rd_en <= 1'b0;
        @(negedge i_clk);
        d = i_rd_data;
    endtask
    // start a counter read, poll until done, then fetch the low word
    task read_count(input logic [7:0] idx, input logic ffe, output logic [31:0] st, output logic [31:0] lo);
        int n;
        wr(12'h0500, {6'h00, 1'b1, ffe, idx, 16'h0000});
        n = 0;
        st = 32'h0200_0000;
        while (st[25] && n < 20) begin
            rd(12'h0500, st);
            n++;
        end
        rd(12'h0504, lo);
    endtask
endmodule

//--- sim/stat_counter_assertions.sv
// assertions on the statistics counter register port
`timescale 1ns/100ps
module stat_counter_checker (
    input wire i_clk,
    input wire i_sys_rst,
    input wire [11:0] i_addr,
    input wire [31:0] i_wr_data,
    input wire i_wr_en,
    input wire i_rd_en,
    input wire [31:0] o_rd_data,
    input wire [29:0] i_cnt_event,
    input wire i_global_flush,
    input wire i_global_freeze,
    input wire o_read_busy,
    input wire o_port_frozen
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    wire csr = i_addr == 12'h0500;
    wire go = i_wr_en && csr && i_wr_data[25];
    a_busy_set: assert property (go && !o_read_busy |=> o_read_busy) else $error("busy not set");
    a_busy_span: assert property ($rose(o_read_busy) |=> o_read_busy ##1 !o_read_busy) else $error("busy span");
    a_busy_cause: assert property ($rose(o_read_busy) |-> $past(go)) else $error("busy without start");
    a_rd_idle: assert property (!i_rd_en |=> o_rd_data == 0) else $error("read data not idle");
    a_unmapped_zero: assert property (i_rd_en && !csr && i_addr != 12'h0504 |=> o_rd_data == 0)
        else $error("unmapped read");
    a_reserved_zero: assert property (i_rd_en && csr |=> o_rd_data[30:26] == 0 && o_rd_data[15:4] == 0)
        else $error("reserved bits");
    a_busy_view: assert property (i_rd_en && csr |=> o_rd_data[25] == $past(o_read_busy)) else $error("bit 25 view");
    a_freeze_cause: assert property (!i_global_freeze |=> !o_port_frozen) else $error("frozen without freeze");
endmodule

bind port_stat_counter_indirect_read stat_counter_checker u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_cnt_event(i_cnt_event), .i_global_flush(i_global_flush), .i_global_freeze(i_global_freeze),
    .o_read_busy(o_read_busy), .o_port_frozen(o_port_frozen));

//--- sim/tb.sv
// testbench for the statistics counter register bank
`timescale 1ns/100ps
module tb;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [29:0] ev = 30'h0000_0000;
    logic flush = 1'b0;
    logic frz = 1'b0;
    wire [11:0] addr;
    wire [31:0] wdata;
    wire [31:0] rdata;
    wire we;
    wire re;
    wire frozen;
    wire busy;
    int miscompares = 0;
    int tests_run = 0;
    logic [31:0] st;
    logic [31:0] lo;
    host_model host (.i_clk(i_clk), .i_rd_data(rdata), .o_addr(addr), .o_wr_data(wdata), .o_wr_en(we), .o_rd_en(re));
    port_stat_counter_indirect_read dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(addr), .i_wr_data(wdata),
        .i_wr_en(we), .i_rd_en(re), .o_rd_data(rdata), .i_cnt_event(ev), .i_global_flush(flush),
        .i_global_freeze(frz), .o_read_busy(busy), .o_port_frozen(frozen));
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task cnt(input logic [7:0] idx, input logic ffe, input logic [31:0] e);
        host.read_count(idx, ffe, st, lo);
        chk("status", {7'h00, ffe, idx, 16'h0000}, st);
        chk("count", e, lo);
    endtask
    task pulse(input int k);
        repeat (k) @(posedge i_clk) ev <= 30'h3fff_ffff;
        @(posedge i_clk) ev <= 30'h0000_0000;
    endtask
    initial begin
        repeat (12) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        host.rd(12'h0500, st);
        chk("csr reset", 32'h0000_0000, st);
        chk("busy reset", 32'h0000_0000, {31'h0000_0000, busy});
        host.wr(12'h0504, 32'hffff_ffff);
        host.rd(12'h0504, st);
        chk("data ro", 32'h0000_0000, st);
        host.rd(12'h0508, st);
        chk("unmapped", 32'h0000_0000, st);
        pulse(5);
        cnt(8'h00, 1'b0, 32'h0000_0005);
        cnt(8'h00, 1'b0, 32'h0000_0000);
        cnt(8'h1d, 1'b0, 32'h0000_0005);
        cnt(8'h1e, 1'b0, 32'h0000_0000);
        host.wr(12'h0500, 32'h0100_0000);
        frz <= 1'b1;
        pulse(3);
        chk("frozen", 32'h0000_0001, {31'h0000_0000, frozen});
        cnt(8'h01, 1'b1, 32'h0000_0005);
        host.wr(12'h0500, 32'h0000_0000);
        pulse(2);
        chk("exempt", 32'h0000_0000, {31'h0000_0000, frozen});
        cnt(8'h02, 1'b0, 32'h0000_0007);
        host.wr(12'h0500, 32'h0100_0000);
        frz <= 1'b0;
        flush <= 1'b1;
        @(posedge i_clk) flush <= 1'b0;
        cnt(8'h03, 1'b1, 32'h0000_0000);
        // a second start while busy must be refused and leave the index alone
        pulse(1);
        host.wr(12'h0500, 32'h0304_0000);
        @(negedge i_clk);
        chk("busy set", 32'h0000_0001, {31'h0000_0000, busy});
        host.wr(12'h0500, 32'h0305_0000);
        host.rd(12'h0500, st);
        chk("index held", 32'h0104_0000, st);
        chk("busy clear", 32'h0000_0000, {31'h0000_0000, busy});
        host.rd(12'h0504, lo);
        chk("count", 32'h0000_0001, lo);
        close_out;
    end
    initial begin
        #200000;
        miscompares++;
        close_out;
    end
endmodule
